// File: design/hbc_pkg.sv
// What this block does
// - Two full comparator slots, zero and one.
// - Slot registers at 220h-237h, three each.
// - Masked 32-bit match value gives comparison.
// - Trigger overwrites match value with observed.
// - Set mask bits are don't-care in comparison.
// - Debug status at 5h shows slot status.
// - Trigger by address and access type.
// - Instruction breakpoints fire on execute, not fetch.
// - Trigger action: halt core or software interrupt.
// - Qualify on reads, writes or both.
// - Invert: trigger when comparison does not match.
// - Gang pairs or quads; all must match.
// - Full slot compares instruction opcode.
// - Full slot compares memory or aux data.
// - Full slot takes two 34-bit extra inputs.
// - Minimal or full capability fixed at build.
// - Bus read address and data never together.
// - Aux data matches on reads and writes.
// - Read plus write monitors write data only.
package hbc_pkg;

	localparam int unsigned APB_AW = 12;

	// Register indices; byte address is four times the index.
	localparam logic [9:0] IDX_STATUS     = 10'h005;
	localparam logic [9:0] IDX_SLOT_BASE  = 10'h220;
	localparam logic [9:0] IDX_SLOT_LAST  = 10'h237;
	localparam int unsigned REGS_PER_SLOT = 3;
	localparam logic [1:0] SUB_VALUE      = 2'h0;
	localparam logic [1:0] SUB_MASK       = 2'h1;
	localparam logic [1:0] SUB_CONTROL    = 2'h2;

	// Control register layout.
	localparam int unsigned CTL_EN_BIT    = 0;
	localparam int unsigned CTL_TYPE_LSB  = 1;
	localparam int unsigned CTL_RD_BIT    = 4;
	localparam int unsigned CTL_WR_BIT    = 5;
	localparam int unsigned CTL_INV_BIT   = 6;
	localparam int unsigned CTL_GANG_LSB  = 7;
	localparam int unsigned CTL_ACT_BIT   = 9;
	localparam int unsigned CTL_WIDTH     = 10;

	typedef enum logic [2:0] {
		HBC_T_INSTR_ADDR,
		HBC_T_INSTR_OPCODE,
		HBC_T_BUS_ADDR,
		HBC_T_BUS_DATA,
		HBC_T_AUX_ADDR,
		HBC_T_AUX_DATA,
		HBC_T_EXT0,
		HBC_T_EXT1
	} hbc_type_t;

	localparam logic [1:0] GANG_NONE = 2'h0;
	localparam logic [1:0] GANG_PAIR = 2'h1;
	localparam logic [1:0] GANG_QUAD = 2'h2;

	// Status register layout.
	localparam int unsigned ST_HALT_BIT = 8;
	localparam int unsigned ST_SWI_BIT  = 9;

	localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
	localparam logic [CTL_WIDTH-1:0] CTL_RESET = 10'h000;

endpackage : hbc_pkg

// File: design/hbc_top.sv
`timescale 1ns/1ps
module hbc_top #(
	parameter int unsigned NUM_SLOTS = 2,
	parameter bit          FULL_CAP  = 1'b1
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [hbc_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       exec_valid,
	input  wire logic [31:0]                exec_pc,
	input  wire logic [31:0]                exec_opcode,
	input  wire logic                       bus_valid,
	input  wire logic                       bus_write,
	input  wire logic [31:0]                bus_addr,
	input  wire logic [31:0]                bus_wdata,
	input  wire logic                       bus_rdata_valid,
	input  wire logic [31:0]                bus_rdata,
	input  wire logic                       aux_valid,
	input  wire logic                       aux_write,
	input  wire logic [31:0]                aux_addr,
	input  wire logic [31:0]                aux_wdata,
	input  wire logic [31:0]                aux_rdata,
	input  wire logic [NUM_SLOTS*34-1:0]    ext_in0,
	input  wire logic [NUM_SLOTS*34-1:0]    ext_in1,
	output logic                            halt_req,
	output logic                            swi_req,
	output logic      [NUM_SLOTS-1:0]       slot_hit
);
	import hbc_pkg::*;

	// Status keeps bits 8 and 9 for the actions, so at most eight slots fit below them.
	if (NUM_SLOTS < 1 || NUM_SLOTS > 8) begin : g_bad_slots
		$error("NUM_SLOTS must lie between 1 and 8.");
	end

	logic [31:0]          value_r [NUM_SLOTS];
	logic [31:0]          mask_r  [NUM_SLOTS];
	logic [CTL_WIDTH-1:0] ctl_r   [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] sticky_r;
	logic                 halt_seen_r;
	logic                 swi_seen_r;
	logic [31:0]          prdata_r;
	logic                 pready_r;
	logic                 pslverr_r;
	logic                 halt_req_r;
	logic                 swi_req_r;
	logic [NUM_SLOTS-1:0] slot_hit_r;

	logic [9:0]           idx;
	logic                 setup;
	logic                 wr_done;
	logic                 hit_status;
	logic                 hit_any_slot;
	logic [NUM_SLOTS-1:0] hit_slot;
	logic [1:0]           hit_sub;
	logic [31:0]          rd_mux;

	logic [NUM_SLOTS-1:0] raw_hit;
	logic [NUM_SLOTS-1:0] fire;
	logic [31:0]          seen    [NUM_SLOTS];
	logic                 act_halt;
	logic                 act_swi;

	assign idx     = 10'(paddr[APB_AW-1:2]);
	assign setup   = psel & ~penable;
	assign wr_done = psel & penable & pready_r & pwrite;

	// Address decode over the status word and the slot window.
	always_comb begin
		hit_status   = (idx == IDX_STATUS) && (paddr[1:0] == 2'h0);
		hit_slot     = '0;
		hit_sub      = SUB_VALUE;
		rd_mux       = 32'h0000_0000;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			for (int r = 0; r < REGS_PER_SLOT; r++) begin
				if (paddr[1:0] == 2'h0 &&
				    idx == IDX_SLOT_BASE + 10'(s * REGS_PER_SLOT + r)) begin
					hit_slot[s] = 1'b1;
					hit_sub     = 2'(r);
				end
			end
		end
		hit_any_slot = |hit_slot;
		if (hit_status) begin
			rd_mux[NUM_SLOTS-1:0] = sticky_r;
			rd_mux[ST_HALT_BIT]   = halt_seen_r;
			rd_mux[ST_SWI_BIT]    = swi_seen_r;
		end
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (hit_slot[s]) begin
				unique case (hit_sub)
					SUB_VALUE:   rd_mux = value_r[s];
					SUB_MASK:    rd_mux = mask_r[s];
					SUB_CONTROL: rd_mux = {{(32-CTL_WIDTH){1'b0}}, ctl_r[s]};
					default:     rd_mux = 32'h0000_0000;
				endcase
			end
		end
	end

	// Zero-wait slave: answer latched in setup, pready high for the one access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~hit_status & ~hit_any_slot;
			if (setup && !pwrite)
				prdata_r <= rd_mux;
			else if (!psel)
				prdata_r <= 32'h0000_0000;
		end
	end

	// Observed value and qualified access per slot.
	always_comb begin
		raw_hit = '0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			logic       en;
			logic       q_rd;
			logic       q_wr;
			logic       acc;
			logic [2:0] typ;
			logic [33:0] e0;
			logic [33:0] e1;
			logic       eq;
			en      = ctl_r[s][CTL_EN_BIT];
			q_rd    = ctl_r[s][CTL_RD_BIT];
			q_wr    = ctl_r[s][CTL_WR_BIT];
			typ     = ctl_r[s][CTL_TYPE_LSB +: 3];
			e0      = ext_in0[s*34 +: 34];
			e1      = ext_in1[s*34 +: 34];
			acc     = 1'b0;
			seen[s] = 32'h0000_0000;
			unique case (hbc_type_t'(typ))
				HBC_T_INSTR_ADDR: begin
					acc     = exec_valid;
					seen[s] = exec_pc;
				end
				HBC_T_INSTR_OPCODE: begin
					acc     = FULL_CAP & exec_valid;
					seen[s] = exec_opcode;
				end
				HBC_T_BUS_ADDR: begin
					acc     = bus_valid & (bus_write ? q_wr : q_rd);
					seen[s] = bus_addr;
				end
				HBC_T_BUS_DATA: begin
					// Address and read data come on separate strobes.
					if (q_wr) begin
						acc     = FULL_CAP & bus_valid & bus_write;
						seen[s] = bus_wdata;
					end else begin
						acc     = FULL_CAP & q_rd & bus_rdata_valid;
						seen[s] = bus_rdata;
					end
				end
				HBC_T_AUX_ADDR: begin
					acc     = aux_valid & (aux_write ? q_wr : q_rd);
					seen[s] = aux_addr;
				end
				HBC_T_AUX_DATA: begin
					if (q_wr) begin
						acc     = FULL_CAP & aux_valid & aux_write;
						seen[s] = aux_wdata;
					end else begin
						acc     = FULL_CAP & q_rd & aux_valid & ~aux_write;
						seen[s] = aux_rdata;
					end
				end
				HBC_T_EXT0: begin
					// Bit 32 strobes the input, bit 33 flags a write.
					acc     = FULL_CAP & e0[32] & (e0[33] ? q_wr : q_rd);
					seen[s] = e0[31:0];
				end
				HBC_T_EXT1: begin
					acc     = FULL_CAP & e1[32] & (e1[33] ? q_wr : q_rd);
					seen[s] = e1[31:0];
				end
			endcase
			eq = ((seen[s] ^ value_r[s]) & ~mask_r[s]) == 32'h0000_0000;
			raw_hit[s] = en & acc & (eq ^ ctl_r[s][CTL_INV_BIT]);
		end
	end

	// Ganging: a member fires only when every present slot of its group hits.
	always_comb begin
		fire     = '0;
		act_halt = 1'b0;
		act_swi  = 1'b0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			logic grp;
			grp = raw_hit[s];
			for (int m = 0; m < NUM_SLOTS; m++) begin
				if (ctl_r[s][CTL_GANG_LSB +: 2] == GANG_PAIR && (m >> 1) == (s >> 1))
					grp = grp & raw_hit[m];
				if (ctl_r[s][CTL_GANG_LSB +: 2] == GANG_QUAD && (m >> 2) == (s >> 2))
					grp = grp & raw_hit[m];
			end
			fire[s] = grp;
			if (grp && !ctl_r[s][CTL_ACT_BIT])
				act_halt = 1'b1;
			if (grp && ctl_r[s][CTL_ACT_BIT])
				act_swi = 1'b1;
		end
	end

	// Slot registers; a trigger's capture wins over a software write in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				value_r[s] <= VALUE_RESET;
				mask_r[s]  <= MASK_RESET;
				ctl_r[s]   <= CTL_RESET;
			end
		end else begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				if (fire[s])
					value_r[s] <= seen[s];
				else if (wr_done && hit_slot[s] && hit_sub == SUB_VALUE)
					value_r[s] <= pwdata;
				if (wr_done && hit_slot[s] && hit_sub == SUB_MASK)
					mask_r[s] <= pwdata;
				if (wr_done && hit_slot[s] && hit_sub == SUB_CONTROL)
					ctl_r[s] <= pwdata[CTL_WIDTH-1:0];
			end
		end
	end

	// Sticky status, write one to clear; a new trigger wins over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_r    <= '0;
			halt_seen_r <= 1'b0;
			swi_seen_r  <= 1'b0;
		end else begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				if (fire[s])
					sticky_r[s] <= 1'b1;
				else if (wr_done && hit_status && pwdata[s])
					sticky_r[s] <= 1'b0;
			end
			if (act_halt)
				halt_seen_r <= 1'b1;
			else if (wr_done && hit_status && pwdata[ST_HALT_BIT])
				halt_seen_r <= 1'b0;
			if (act_swi)
				swi_seen_r <= 1'b1;
			else if (wr_done && hit_status && pwdata[ST_SWI_BIT])
				swi_seen_r <= 1'b0;
		end
	end

	// Action pulses toward the core, one cycle after the triggering access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_req_r <= 1'b0;
			swi_req_r  <= 1'b0;
			slot_hit_r <= '0;
		end else begin
			halt_req_r <= act_halt;
			swi_req_r  <= act_swi;
			slot_hit_r <= fire;
		end
	end

	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign halt_req = halt_req_r;
	assign swi_req  = swi_req_r;
	assign slot_hit = slot_hit_r;

endmodule : hbc_top

// File: sim/hbc_properties.sv
`timescale 1ns/1ps
module hbc_checker #(
	parameter int unsigned NUM_SLOTS = 2
) (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic [11:0]             paddr,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    exec_valid,
	input wire logic                    bus_valid,
	input wire logic                    bus_rdata_valid,
	input wire logic                    aux_valid,
	input wire logic [NUM_SLOTS*34-1:0] ext_in0,
	input wire logic [NUM_SLOTS*34-1:0] ext_in1,
	input wire logic                    halt_req,
	input wire logic                    swi_req,
	input wire logic [NUM_SLOTS-1:0]    slot_hit
);
	logic any_acc;
	always_comb begin
		any_acc = exec_valid | bus_valid | bus_rdata_valid | aux_valid;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			any_acc = any_acc | ext_in0[s*34+32] | ext_in1[s*34+32];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	AST_UNMAPPED_ERR: assert property (psel && !penable
		&& (paddr[1:0] != 2'h0 || paddr[11:2] < 10'h005) |=> pslverr)
		else $error("unmapped access not refused");
	AST_STATUS_OK: assert property (psel && !penable && paddr == 12'h014 |=> !pslverr)
		else $error("status access refused");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr outside access phase");
	AST_HIT_NEEDS_ACCESS: assert property (slot_hit != '0 |-> $past(any_acc))
		else $error("slot fired without an access");
	AST_ACTION_NEEDS_HIT: assert property (halt_req || swi_req |-> slot_hit != '0)
		else $error("action without slot hit");
	AST_HIT_GIVES_ACTION: assert property (slot_hit != '0 |-> halt_req || swi_req)
		else $error("slot hit without action");
	AST_RESET_QUIET: assert property ($rose(presetn) |-> slot_hit == '0 && !halt_req)
		else $error("outputs active at reset release");
endmodule : hbc_checker
bind hbc_top hbc_checker #(.NUM_SLOTS(NUM_SLOTS)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.exec_valid(exec_valid), .bus_valid(bus_valid), .bus_rdata_valid(bus_rdata_valid),
	.aux_valid(aux_valid), .ext_in0(ext_in0), .ext_in1(ext_in1), .halt_req(halt_req),
	.swi_req(swi_req), .slot_hit(slot_hit));

// File: sim/hbc_core_model.sv
`timescale 1ns/1ps
module hbc_core_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        go,
	input  wire logic [2:0]  kind,
	input  wire logic [31:0] a,
	input  wire logic [31:0] d,
	output logic             exec_v,
	output logic             bus_v,
	output logic             bus_w,
	output logic             rd_v,
	output logic             aux_v,
	output logic             aux_w,
	output logic             ext_v,
	output logic             ext_w,
	output logic [31:0]      addr,
	output logic [31:0]      data
);
	logic [31:0] d_hold;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{exec_v, bus_v, bus_w, rd_v, aux_v, aux_w, ext_v, ext_w} <= 8'h00;
			addr   <= 32'h0;
			data   <= 32'h0;
			d_hold <= 32'h0;
		end else begin
			exec_v <= go && kind == 3'h0;
			bus_v  <= go && (kind == 3'h1 || kind == 3'h2);
			bus_w  <= go && kind == 3'h2;
			aux_v  <= go && (kind == 3'h3 || kind == 3'h4);
			aux_w  <= go && kind == 3'h4;
			// Kind five reads and kind six writes through the extra inputs.
			ext_v  <= go && (kind == 3'h5 || kind == 3'h6);
			ext_w  <= go && kind == 3'h6;
			// Read data comes back one cycle after the address phase.
			rd_v   <= bus_v && !bus_w;
			d_hold <= go ? d : d_hold;
			// Idle lines toggle so a stale value can never pass for a match.
			addr   <= go ? a : ~addr;
			data   <= (go && kind != 3'h1) ? d : (bus_v && !bus_w) ? d_hold : ~data;
		end
	end
endmodule : hbc_core_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import hbc_pkg::*;
	localparam logic [31:0] SOFT_BREAK_INSTRUCTION = 32'h0000_7FFF;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hBBA9, ga = 32'h0, gd = 32'h0;
	logic [31:0] m_a, m_d, r, a, d, s, vv[2], mm[2];
	logic        pready, pslverr, halt_req, swi_req, er, go = 1'b0, f0, f1, fa;
	logic        m_ev, m_bv, m_bw, m_rv, m_av, m_aw, m_xv, m_xw;
	logic [2:0]  kind = 3'h0, k, t;
	logic [1:0]  slot_hit, q;
	logic [9:0]  c;
	logic [32:0] h0, h1;
	int          errors = 0, checks = 0, nh = 0, ns = 0, n0 = 0, n1 = 0, bh, bs, b0, b1;
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (halt_req === 1'b1) nh++;
		if (swi_req === 1'b1) ns++;
		if (slot_hit[0] === 1'b1) n0++;
		if (slot_hit[1] === 1'b1) n1++;
	end
	hbc_core_model u_core (.clk(pclk), .rstn(presetn), .go(go), .kind(kind), .a(ga), .d(gd),
		.exec_v(m_ev), .bus_v(m_bv), .bus_w(m_bw), .rd_v(m_rv), .aux_v(m_av), .aux_w(m_aw),
		.ext_v(m_xv), .ext_w(m_xw), .addr(m_a), .data(m_d));
	hbc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exec_valid(m_ev), .exec_pc(m_a), .exec_opcode(m_d),
		.bus_valid(m_bv), .bus_write(m_bw), .bus_addr(m_a), .bus_wdata(m_d),
		.bus_rdata_valid(m_rv), .bus_rdata(m_d), .aux_valid(m_av), .aux_write(m_aw),
		.aux_addr(m_a), .aux_wdata(m_d), .aux_rdata(~m_d), .ext_in0({2{m_xw, m_xv, m_d}}),
		.ext_in1({2{m_xw, m_xv, ~m_d}}), .halt_req(halt_req), .swi_req(swi_req),
		.slot_hit(slot_hit));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Returns the hit flag above the value the slot watches for this access.
	function automatic logic [32:0] f_hit(input logic [9:0] c, input logic [31:0] v, m,
		input logic [2:0] k, input logic [31:0] a, d);
		logic sel;
		logic [31:0] s;
		s = (c[1] || c[3:2] == 2'b11) ? d : a;
		// Aux read data and the second extra input carry the inverted data word.
		if (c[3:1] == 3'h7 || (c[3:1] == 3'h5 && !c[5]))
			s = ~d;
		case (c[3:1])
			3'h0, 3'h1: sel = (k == 3'h0);
			3'h2: sel = (k == 3'h1 && c[4]) || (k == 3'h2 && c[5]);
			3'h3: sel = c[5] ? (k == 3'h2) : (k == 3'h1);
			3'h4: sel = (k == 3'h3 && c[4]) || (k == 3'h4 && c[5]);
			3'h5: sel = c[5] ? (k == 3'h4) : (k == 3'h3);
			default: sel = (k == 3'h5 && c[4]) || (k == 3'h6 && c[5]);
		endcase
		return {c[0] && sel && ((((s ^ v) & ~m) == 32'h0) ^ c[6]), s};
	endfunction : f_hit
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic final_report();
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	initial begin
		#50000;
		errors++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, (i == 6) ? 12'h014 : 12'h880 + 12'(4 * i), 32'h0);
			chk("reset value", 32'h0, rd);
		end
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk("unmapped err", 32'h1, {31'h0, er});
		apb(1'b0, 12'h886, 32'h0);
		chk("misaligned err", 32'h1, {31'h0, er});
		for (int i = 0; i < 40; i++) begin
			r = xs();
			t = i[2:0];
			q = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
			c = {r[2], r[4:3], r[6:5] == 2'h0, q[1], q[0], t, 1'b1};
			k = (t < 3'h2) ? 3'h0 : (t[2:1] == 2'h3) ? 3'h5 + {2'h0, r[7]} :
				(t[2] ? 3'h3 : 3'h1) + {2'h0, r[7]};
			a = xs();
			// A hardware slot stands in for the break instruction in read-only code.
			d = (i == 1) ? SOFT_BREAK_INSTRUCTION : xs();
			h0 = f_hit(c, 32'h0, 32'h0, k, a, d);
			s = h0[31:0];
			// Aligned power-of-two masks, with at most one flipped bit at a random position inside or outside them.
			for (int j = 0; j < 2; j++) begin
				mm[j] = (32'h1 << r[12+4*j-:4]) - 32'h1;
				vv[j] = r[8+j] ? s ^ (32'h1 << r[20+5*j-:5]) : s;
			end
			apb(1'b1, 12'h014, 32'h0000_03FF);
			for (int j = 0; j < 2; j++) begin
				apb(1'b1, 12'h880 + 12'(12 * j), vv[j]);
				apb(1'b1, 12'h884 + 12'(12 * j), mm[j]);
				apb(1'b1, 12'h888 + 12'(12 * j), {22'h0, c});
				chk("write err", 32'h0, {31'h0, er});
			end
			h0 = f_hit(c, vv[0], mm[0], k, a, d);
			h1 = f_hit(c, vv[1], mm[1], k, a, d);
			f0 = (c[8:7] == 2'h1 || c[8:7] == 2'h2) ? h0[32] & h1[32] : h0[32];
			f1 = (c[8:7] == 2'h1 || c[8:7] == 2'h2) ? h0[32] & h1[32] : h1[32];
			fa = f0 | f1;
			{bh, bs, b0, b1} = {nh, ns, n0, n1};
			@(posedge pclk);
			go   <= 1'b1;
			kind <= k;
			ga   <= a;
			gd   <= d;
			@(posedge pclk);
			go <= 1'b0;
			repeat (4) @(posedge pclk);
			chk("halt pulses", {31'h0, fa & ~c[9]}, 32'(nh - bh));
			chk("swi pulses", {31'h0, fa & c[9]}, 32'(ns - bs));
			chk("slot0 hits", {31'h0, f0}, 32'(n0 - b0));
			chk("slot1 hits", {31'h0, f1}, 32'(n1 - b1));
			for (int j = 0; j < 2; j++) begin
				apb(1'b0, 12'h880 + 12'(12 * j), 32'h0);
				chk("captured value", ((j == 0) ? f0 : f1) ? s : vv[j], rd);
			end
			apb(1'b0, 12'h888, 32'h0);
			chk("control", {22'h0, c}, rd);
			apb(1'b0, 12'h014, 32'h0);
			chk("status", {22'h0, fa & c[9], fa & ~c[9], 6'h0, f1, f0}, rd & 32'h3FF);
		end
		apb(1'b1, 12'h014, 32'h0000_03FF);
		apb(1'b0, 12'h014, 32'h0);
		chk("status cleared", 32'h0, rd & 32'h3FF);
		// A reset in mid-run must disarm every slot that the loop left enabled.
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h888, 32'h0);
		chk("control after reset", 32'h0, rd);
		b0 = n0 + n1;
		@(posedge pclk);
		go   <= 1'b1;
		kind <= 3'h0;
		@(posedge pclk);
		go <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("hits after reset", 32'h0, 32'(n0 + n1 - b0));
		final_report();
	end
endmodule : tb_top
